// ---- core/fault_shutdown_ctrl.sv ----
`timescale 1ns/1ns
// Fault reaction controller: decides switch-offs and safety enables
module fault_shutdown_ctrl (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic [fault_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  input  wire fault_pkg::fault_rpt_s      fault_pins,
  output logic [fault_pkg::NUM_BUSES-1:0] safety_enable_signal,
  output fault_pkg::slot_mask_t           module_off,
  output fault_pkg::slot_mask_t           input_zero,
  output fault_pkg::err_disp_s            err_display,
  output logic                            irq
);
  import fault_pkg::*;

  // Synchronised fault reports
  // Every fault pin is a level from another module and may change at any
  // time, so nothing reads the raw pins before the second flop
  fault_rpt_s                         flt;
  logic [RPT_W-1:0]                   flt_vec;

  // Software state
  // Written over the register bus; a change takes effect on the next edge
  // Reset leaves normal operation, one bus and no groups
  react_mode_e                        mode_q;      // Reaction parameter
  topo_e                              topo_q;      // Redundancy variant
  logic [NUM_BUSES-1:0]               estop_q;     // Emergency shutdown variable
  slot_mask_t [NUM_GROUPS-1:0]        grp_q;       // Group membership
  logic [NUM_IRQ-1:0]                 irq_mask_q;
  logic [NUM_IRQ-1:0]                 irq_stat_q;
  logic [NUM_IRQ-1:0]                 irq_stat_d;

  // Latched reaction state
  // Each latch only moves toward the safe side until a restart write;
  // a recovering fault must never re-energise an output by itself
  logic [NUM_BUSES-1:0]               enable_q;
  logic [NUM_BUSES-1:0]               enable_d;
  slot_mask_t                         off_q;
  slot_mask_t                         off_d;
  slot_mask_t                         zero_q;
  slot_mask_t                         zero_d;
  err_disp_s                          err_q;
  err_disp_s                          err_d;
  logic [NUM_GROUPS-1:0]              ovf_q;       // Previous overflow, for edge

  // Bus slave state
  // Waitrequest rests high so that every access costs exactly two cycles
  logic                               wait_q;
  logic [31:0]                        rdata_q;
  logic                               irq_q;

  pin_sync #(
    .W (RPT_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     (fault_pins),
    .dout    (flt_vec)
  );
  assign flt = fault_rpt_s'(flt_vec);

  // Bus decode; a request is taken when it meets a low waitrequest
  // Byte lanes mask the write data, so a partial write clears other lanes
  // Unmapped writes decode to nothing and are dropped
  wire        req        = avs_read | avs_write;
  wire        acc        = req && !wait_q;
  wire        wr         = acc && avs_write;
  wire [31:0] be_mask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wbits      = avs_writedata & be_mask;
  wire        hit_ctrl   = avs_address == OFF_CTRL;
  wire        hit_rst    = avs_address == OFF_RESTART;
  wire        hit_status = avs_address == OFF_STATUS;
  wire        hit_swoff  = avs_address == OFF_SWOFF;
  wire        hit_zero   = avs_address == OFF_INZERO;
  wire        hit_err    = avs_address == OFF_ERRDISP;
  wire        hit_istat  = avs_address == OFF_IRQ_STAT;
  wire        hit_imask  = avs_address == OFF_IRQ_MASK;
  wire        restart    = wr && hit_rst && wbits[RESTART_BIT];   // (R15)
  wire [NUM_IRQ-1:0] irq_clr = (wr && hit_istat) ? wbits[NUM_IRQ-1:0] : '0;

  // Mode decode; reserved mode treated as the strictest reaction
  // Emergency off is the fallback, so a corrupted mode word errs toward
  // dropping the enable rather than keeping outputs live
  wire disp   = mode_q == MODE_DISPLAY;
  wire norm   = mode_q == MODE_NORMAL;
  wire emerg  = !disp && !norm;
  wire redund = topo_q == TOPO_REDUNDANT;
  wire shared = topo_q == TOPO_SHARED;

  // Output modules judged faulty; loss of supply arrives as single fault
  // Single and double faults both mark the module as faulty here; the
  // difference only matters for the enable decision and the error display below
  wire slot_mask_t out_flt = flt.out_single | flt.out_double;

  // Module switch-off under display only or normal operation
  wire slot_mask_t mod_off = (disp || norm) ? out_flt : '0;   // (R01)

  // Group shutdown, active only under normal operation
  // The expander is purely combinational, so group members switch off in
  // the same cycle as the faulty module itself
  slot_mask_t            grp_off;
  logic [NUM_GROUPS-1:0] grp_ovf;
  group_shutdown_block u_grp (
    .enable    (norm),
    .members   (grp_q),
    .faulted   (out_flt),
    .group_off (grp_off),
    .overflow  (grp_ovf)
  );

  // Slots whose fault needs the enable removed; none under display only
  // Under normal operation only a double fault counts, since a single fault
  // is already handled by the module's own shutdown
  wire slot_mask_t slot_kill = emerg ? out_flt :                 // (R04)
                               norm  ? flt.out_double : '0;      // (R06) (R11) (R10)
  wire [NUM_BUSES-1:0] bus_kill = disp ? '0 : flt.bus_fault;      // (R06)

  // Slot to bus mapping; with one bus every slot counts toward bus 0
  // In the shared variant the bus 0 result feeds both central modules
  // Slots outside 1 to 13 do not exist, so no bit is left unmapped
  wire slot_mask_t b0_slots = redund ? BUS0_SLOTS : ALL_SLOTS;    // (R14)
  wire kill_b0 = bus_kill[0] | (|(slot_kill & b0_slots));
  wire kill_b1 = redund && (bus_kill[1] | (|(slot_kill & BUS1_SLOTS)));  // (R14)

  // Bus kill to central modules; input faults never take part
  // Central faults and the emergency variable bypass the mode decode
  // An input fault only forces its inputs to zero
  wire [NUM_BUSES-1:0] topo_kill = redund ? {kill_b1, kill_b0} :      // (R13)
                                   shared ? {2{kill_b0}} :            // (R12)
                                            {1'b0, kill_b0};
  wire [NUM_BUSES-1:0] cu_kill = topo_kill | flt.central_fault |     // (R07)
                                 estop_q;                             // (R09) (R08)

  // Display entry: first double-faulted slot, else the faulty bus
  // Only one entry is shown; with several double faults the lowest slot
  // wins and the rest stay visible in the switch-off register
  function automatic logic [3:0] first_slot(input slot_mask_t m);
    logic [3:0] s;
    s = 4'h0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (m[i]) begin
        s = 4'(i + 1);
      end
    end
    return s;
  endfunction : first_slot

  // Display errors exist only under display only; other modes drop enables
  wire err_set = disp && ((|flt.out_double) || (|flt.bus_fault));   // (R05)

  // Next display value; a new fault overwrites, restart clears
  // A fault present in the restart cycle is shown again at once
  always_comb begin
    err_d = restart ? '0 : err_q;
    if (err_set) begin
      err_d.valid = 1'b1;
      if (|flt.out_double) begin
        err_d.code = ERR_DOUBLE;
        err_d.slot = first_slot(flt.out_double);
      end else if (flt.bus_fault[0]) begin
        err_d.code = ERR_BUS0;
        err_d.slot = 4'h0;
      end else begin
        err_d.code = ERR_BUS1;
        err_d.slot = 4'h0;
      end
    end
  end

  // Latches: restart releases them, a standing fault wins over restart
  // Restart alone cannot re-energise a module whose fault still stands
  // Input zeroing latches too, so a flickering input module stays at zero
  assign enable_d = (restart ? {NUM_BUSES{1'b1}} : enable_q) & ~cu_kill;  // (R15)
  assign off_d    = (restart ? '0 : off_q) | mod_off | grp_off;            // (R15)
  assign zero_d   = (restart ? '0 : zero_q) | flt.in_fault;               // (R08)

  // Events set sticky bits; a set in the clearing cycle survives
  // Display errors raise their event in every cycle the fault is present
  // Clearing and setting in one cycle keeps the bit set
  wire [NUM_IRQ-1:0] irq_ev;
  assign irq_ev[IRQ_ENABLE_DROP] = |(enable_q & ~enable_d);
  assign irq_ev[IRQ_MODULE_OFF]  = |(off_d & ~off_q);
  assign irq_ev[IRQ_INPUT_ZERO]  = |(zero_d & ~zero_q);
  assign irq_ev[IRQ_ERR_DISPLAY] = err_set;
  assign irq_ev[IRQ_GROUP_OVF]   = |(grp_ovf & ~ovf_q);
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;

  // Read mux; unmapped addresses read as zero
  // Group registers sit at consecutive words and are decoded last
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0;
    if (hit_ctrl) begin
      rmux[CTRL_MODE_LSB +: 2]          = mode_q;
      rmux[CTRL_TOPO_LSB +: 2]          = topo_q;
      rmux[CTRL_ESTOP_LSB +: NUM_BUSES] = estop_q;
    end else if (hit_status) begin
      rmux[NUM_BUSES-1:0] = enable_q;
    end else if (hit_swoff) begin
      rmux[NUM_SLOTS-1:0] = off_q;
    end else if (hit_zero) begin
      rmux[NUM_SLOTS-1:0] = zero_q;
    end else if (hit_err) begin
      rmux[$bits(err_disp_s)-1:0] = err_q;
    end else if (hit_istat) begin
      rmux[NUM_IRQ-1:0] = irq_stat_q;
    end else if (hit_imask) begin
      rmux[NUM_IRQ-1:0] = irq_mask_q;
    end else begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        if (avs_address == OFF_GROUP0 + ADDR_W'(4 * g)) begin
          rmux[NUM_SLOTS-1:0] = grp_q[g];
        end
      end
    end
  end

  // Slave handshake: one wait cycle, answer on the next edge
  // Read data is captured while waitrequest is still high, so it is
  // registered and stable at the completing edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q  <= !(req && wait_q);
      if (req && wait_q) begin
        rdata_q <= rmux;
      end
    end
  end

  // Control register; a write mid-fault takes effect next cycle
  // Mode, topology and emergency bits share one word, written together
  // The mask register shares this process but has its own address
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q     <= MODE_NORMAL;
      topo_q     <= TOPO_MONO;
      estop_q    <= '0;
      irq_mask_q <= '0;
    end else if (wr && hit_ctrl) begin
      mode_q  <= react_mode_e'(wbits[CTRL_MODE_LSB +: 2]);
      topo_q  <= topo_e'(wbits[CTRL_TOPO_LSB +: 2]);
      estop_q <= wbits[CTRL_ESTOP_LSB +: NUM_BUSES];
    end else if (wr && hit_imask) begin
      irq_mask_q <= wbits[NUM_IRQ-1:0];
    end
  end

  // Group membership registers, one per group
  // An oversized group is kept as written but ignored by the expander
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_reg
    wire hit_g = avs_address == OFF_GROUP0 + ADDR_W'(4 * g);
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        grp_q[g] <= '0;
      end else if (wr && hit_g) begin
        grp_q[g] <= wbits[NUM_SLOTS-1:0];
      end
    end
  end

  // Reaction latches and interrupt state
  // The interrupt output changes at the same edge as the status
  // Overflow history is kept only to raise its event on the rising edge
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      enable_q   <= {NUM_BUSES{1'b1}};
      off_q      <= '0;
      zero_q     <= '0;
      err_q      <= '0;
      ovf_q      <= '0;
      irq_stat_q <= '0;
      irq_q      <= 1'b0;
    end else begin
      enable_q   <= enable_d;
      off_q      <= off_d;
      zero_q     <= zero_d;
      err_q      <= err_d;
      ovf_q      <= grp_ovf;
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_d & irq_mask_q);
    end
  end

  // Outputs straight from flops
  // No output passes through logic after its flop, keeping their timing
  // independent of the bus and fault logic
  assign avs_waitrequest      = wait_q;
  assign avs_readdata         = rdata_q;
  assign safety_enable_signal = enable_q;
  assign module_off           = off_q;
  assign input_zero           = zero_q;
  assign err_display          = err_q;
  assign irq                  = irq_q;
endmodule : fault_shutdown_ctrl

// ---- inc/fault_pkg.sv ----
// Contract
// (R01) Single output fault switches that module off; the code does so only under display only and normal operation
// (R02) Normal mode: fault switches whole group off
// (R03) Group holds at most ten output modules
// (R04) Emergency off: output fault drops safety enable
// (R05) Display only: show slot code, keep enable
// (R06) Double or bus fault drops enable otherwise
// (R07) Central module fault always drops its enable
// (R08) Input fault forces inputs zero, keeps enable
// (R09) Emergency shutdown variable always drops enable
// (R10) Display only never drops enable for outputs
// (R11) Normal mode adds enable drop when needed
// (R12) Shared bus: drop both central enables
// (R13) Redundant buses: drop only related enable
// (R14) Slots 1-7 first bus, 8-13 second
// (R15) Removed enables and switch-offs stay latched
package fault_pkg;
  localparam int NUM_SLOTS         = 13;    // I/O slots 1..13
  localparam int NUM_BUSES         = 2;     // Buses, also central modules
  localparam int NUM_GROUPS        = 4;     // Shutdown groups held
  localparam int FIRST_BUS_SLOTS   = 7;     // Slots 1..7 sit on first bus
  localparam logic [3:0] MAX_GROUP_MEMBERS = 4'ha;  // Ten members at most
  localparam int ADDR_W            = 8;     // Byte address width
  localparam int NUM_IRQ           = 5;     // Interrupt events

  typedef logic [NUM_SLOTS-1:0] slot_mask_t;
  localparam slot_mask_t BUS0_SLOTS = 13'h007f;  // Slots 1..7
  localparam slot_mask_t BUS1_SLOTS = 13'h1f80;  // Slots 8..13
  localparam slot_mask_t ALL_SLOTS  = 13'h1fff;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RESTART  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_GROUP0   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_SWOFF    = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_INZERO   = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_ERRDISP  = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h34;

  // Control register fields
  localparam int CTRL_MODE_LSB  = 0;   // 2 bits
  localparam int CTRL_TOPO_LSB  = 2;   // 2 bits
  localparam int CTRL_ESTOP_LSB = 4;   // 2 bits, one per central module
  localparam int RESTART_BIT    = 0;

  // Interrupt bits
  localparam int IRQ_ENABLE_DROP = 0;
  localparam int IRQ_MODULE_OFF  = 1;
  localparam int IRQ_INPUT_ZERO  = 2;
  localparam int IRQ_ERR_DISPLAY = 3;
  localparam int IRQ_GROUP_OVF   = 4;

  // Error display codes
  localparam logic [1:0] ERR_NONE   = 2'h0;
  localparam logic [1:0] ERR_DOUBLE = 2'h1;
  localparam logic [1:0] ERR_BUS0   = 2'h2;
  localparam logic [1:0] ERR_BUS1   = 2'h3;

  typedef enum logic [1:0] {
    MODE_DISPLAY = 2'b00,
    MODE_NORMAL  = 2'b01,
    MODE_EMERG   = 2'b10,
    MODE_RSVD    = 2'b11
  } react_mode_e;

  typedef enum logic [1:0] {
    TOPO_MONO      = 2'b00,
    TOPO_SHARED    = 2'b01,
    TOPO_REDUNDANT = 2'b10,
    TOPO_RSVD      = 2'b11
  } topo_e;

  // Fault reports from the modules, one bit per slot or bus
  typedef struct packed {
    slot_mask_t           out_single;
    slot_mask_t           out_double;
    slot_mask_t           in_fault;
    logic [NUM_BUSES-1:0] bus_fault;
    logic [NUM_BUSES-1:0] central_fault;
  } fault_rpt_s;

  // Bus status display entry
  typedef struct packed {
    logic       valid;
    logic [1:0] code;
    logic [3:0] slot;
  } err_disp_s;

  localparam int RPT_W = $bits(fault_rpt_s);
endpackage : fault_pkg

// ---- core/pin_sync.sv ----
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous fault pins
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;   // First stage, read only by second stage

  // Plain double flop; no logic looks at the first stage
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : pin_sync

// ---- core/group_shutdown_block.sv ----
`timescale 1ns/1ns
// Expands a faulty output module to its whole shutdown group
module group_shutdown_block (
  input  wire logic                                       enable,
  input  wire fault_pkg::slot_mask_t [fault_pkg::NUM_GROUPS-1:0] members,
  input  wire fault_pkg::slot_mask_t                      faulted,
  output fault_pkg::slot_mask_t                           group_off,
  output logic [fault_pkg::NUM_GROUPS-1:0]                overflow
);
  import fault_pkg::*;

  slot_mask_t chain [NUM_GROUPS+1];   // Running OR across groups

  // Counts members of one group
  function automatic logic [3:0] count_ones(input slot_mask_t m);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      n = n + {3'h0, m[i]};
    end
    return n;
  endfunction : count_ones

  assign chain[0] = '0;

  // One evaluator per group
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
    wire too_many = count_ones(members[g]) > MAX_GROUP_MEMBERS;   // (R03)
    wire hit      = |(members[g] & faulted);
    // Oversized group is refused outright rather than partly honoured
    assign overflow[g]  = too_many;
    assign chain[g + 1] = chain[g] |
                          ((enable && hit && !too_many) ? members[g] : '0);  // (R02)
  end

  assign group_off = chain[NUM_GROUPS];
endmodule : group_shutdown_block

// ---- verif/fault_shutdown_ctrl_assertions.sv ----
`timescale 1ns/1ns
// Port-level checks on the fault reaction controller
module fault_shutdown_ctrl_assertions (
  input wire logic                            clk_sys,
  input wire logic                            reset,
  input wire logic [fault_pkg::ADDR_W-1:0]    avs_address,
  input wire logic                            avs_read,
  input wire logic                            avs_write,
  input wire logic [31:0]                     avs_readdata,
  input wire logic                            avs_waitrequest,
  input wire fault_pkg::fault_rpt_s           fault_pins,
  input wire logic [fault_pkg::NUM_BUSES-1:0] safety_enable_signal,
  input wire fault_pkg::slot_mask_t           module_off,
  input wire fault_pkg::slot_mask_t           input_zero,
  input wire fault_pkg::err_disp_s            err_display
);
  import fault_pkg::*;
  // Restart write taking effect; latches may open one cycle later
  wire rst_wr = avs_write && !avs_waitrequest && avs_address == OFF_RESTART;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_one_cycle;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("waitrequest low too long");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address == 8'h3c |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_central;
    fault_pins.central_fault[0] [*3] |=> !safety_enable_signal[0];
  endproperty
  a_central: assert property (p_central) else $error("central fault kept enable");
  property p_in_zero;
    fault_pins.in_fault[12] [*3] |=> input_zero[12];
  endproperty
  a_in_zero: assert property (p_in_zero) else $error("inputs not forced zero");
  // Latches only open through restart, never on fault recovery
  property p_en_latch;
    !rst_wr && !$past(rst_wr) |=> (safety_enable_signal & ~$past(safety_enable_signal)) == 2'h0;
  endproperty
  a_en_latch: assert property (p_en_latch) else $error("enable came back");
  property p_off_latch;
    !rst_wr && !$past(rst_wr) |=> (module_off & $past(module_off)) == $past(module_off);
  endproperty
  a_off_latch: assert property (p_off_latch) else $error("switch-off released");
  property p_reset_vals;
    $past(reset) |-> safety_enable_signal == 2'h3 && module_off == 13'h0 && input_zero == 13'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset outputs");
  property p_err_fmt;
    err_display.valid |-> (err_display.code == ERR_DOUBLE) ?
      (err_display.slot inside {[4'h1:4'hd]}) : (err_display.slot == 4'h0);
  endproperty
  a_err_fmt: assert property (p_err_fmt) else $error("bad display slot");
endmodule : fault_shutdown_ctrl_assertions
bind fault_shutdown_ctrl fault_shutdown_ctrl_assertions chk_inst (.clk_sys, .reset, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .fault_pins, .safety_enable_signal,
  .module_off, .input_zero, .err_display);

// ---- verif/io_modules.sv ----
`timescale 1ns/1ns
// Stand-in for the I/O modules reporting faults as plain levels
module io_modules (
  input  wire logic                        clk_sys,
  input  wire logic [fault_pkg::RPT_W-1:0] inject,
  output fault_pkg::fault_rpt_s            fault_pins
);
  import fault_pkg::*;
  // Supply loss is reported like any single output fault; pins change on the falling clock edge
  always @(negedge clk_sys) fault_pins <= fault_rpt_s'(inject);
endmodule : io_modules

// ---- verif/tb.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
// Reads are predicted into a queue and judged when they complete
module tb;
  import fault_pkg::*;
  logic             clk_sys = 1'b0;
  logic             reset = 1'b1;
  logic [7:0]       avs_address = 8'h0;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = 32'h0;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic [RPT_W-1:0] inject = '0;     // Faults the modules report
  fault_rpt_s       fault_pins;
  logic [1:0]       safety_enable_signal;
  slot_mask_t       module_off;
  slot_mask_t       input_zero;
  err_disp_s        err_display;
  logic             irq;
  logic [63:0]      notes[$];        // {mask, expected} per read
  logic [63:0]      note;
  int               bad_count = 0;
  int               n_compared = 0;
  int               cyc = 0;
  int               s;
  always #2 clk_sys = ~clk_sys;
  io_modules io_modules_inst (.clk_sys, .inject, .fault_pins);
  // Byte lanes stay full: every register is one word
  fault_shutdown_ctrl fault_shutdown_ctrl_inst (.clk_sys, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .fault_pins, .safety_enable_signal, .module_off, .input_zero, .err_display, .irq);
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // Oldest prediction is taken when a read completes
  always @(posedge clk_sys) begin
    if (avs_read && !avs_waitrequest) begin
      note = notes.pop_front();
      `CHK($sformatf("read %h", avs_address), note[31:0], avs_readdata & note[63:32])
    end
  end
  // Hang guard, far above the run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      give_verdict();
    end
  end
  // Request held until waitrequest is sampled low, then released
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({m, e & m});
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic do_reset();
    inject <= '0;
    reset  <= 1'b1;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
  endtask : do_reset
  // One fault case: configure, inject, wait the pin latency, read back
  task automatic scen(input logic [5:0] c, input slot_mask_t g, input logic [RPT_W-1:0] f,
    input logic [1:0] en, input slot_mask_t off, input slot_mask_t zr, input logic [6:0] er);
    do_reset();
    xfer(1'b1, OFF_CTRL, {26'h0, c});
    xfer(1'b1, OFF_GROUP0, {19'h0, g});
    inject <= f;
    repeat (4) @(posedge clk_sys);
    rd(OFF_STATUS, {30'h0, en}, 32'h3);
    rd(OFF_SWOFF, {19'h0, off}, 32'h1fff);
    rd(OFF_INZERO, {19'h0, zr}, 32'h1fff);
    if (c[1:0] == 2'h0) rd(OFF_ERRDISP, {25'h0, er}, 32'h7f);
    `CHK("enable pins", en, safety_enable_signal)
    `CHK("off pins", off, module_off)
    `CHK("zero pins", zr, input_zero)
    `CHK("display pins", er, err_display)
  endtask : scen
  // Fault goes away; latch holds until restart
  task automatic latch(input logic [7:0] a, input logic [31:0] held, input logic [31:0] after);
    inject <= '0;
    repeat (4) @(posedge clk_sys);
    rd(a, held, 32'h1fff);
    xfer(1'b1, OFF_RESTART, 32'h1);
    repeat (4) @(posedge clk_sys);
    rd(a, after, 32'h1fff);
  endtask : latch
  initial begin
    void'($urandom(32'hc0f61b2e));
    do_reset();
    rd(OFF_CTRL, 32'h1, 32'h3f);
    rd(OFF_STATUS, 32'h3, 32'h3);
    rd(OFF_IRQ_MASK, 32'h0, 32'h1f);
    rd(8'h3c, 32'h0, 32'hffffffff);
    s = $urandom_range(0, 31);
    xfer(1'b1, OFF_IRQ_MASK, s);
    rd(OFF_IRQ_MASK, s, 32'h1f);
    scen(6'h00, 13'h0, {13'h4, 30'h0}, 2'h3, 13'h4, 13'h0, 7'h0);
    xfer(1'b1, OFF_IRQ_MASK, 32'h2);
    repeat (3) @(posedge clk_sys);
    `CHK("irq raised", 1'b1, irq)
    rd(OFF_IRQ_STAT, 32'h2, 32'h2);
    xfer(1'b1, OFF_IRQ_STAT, 32'h2);
    repeat (3) @(posedge clk_sys);
    `CHK("irq cleared", 1'b0, irq)
    latch(OFF_SWOFF, 32'h4, 32'h0);
    scen(6'h01, 13'h24, {13'h4, 30'h0}, 2'h3, 13'h24, 13'h0, 7'h0);
    scen(6'h01, 13'h3ff, {13'h1, 30'h0}, 2'h3, 13'h3ff, 13'h0, 7'h0);
    scen(6'h01, 13'h7ff, {13'h1, 30'h0}, 2'h3, 13'h1, 13'h0, 7'h0);
    rd(OFF_IRQ_STAT, 32'h10, 32'h10);
    scen(6'h02, 13'h0, {13'h10, 30'h0}, 2'h2, 13'h0, 13'h0, 7'h0);
    rd(OFF_IRQ_STAT, 32'h1, 32'h1);
    latch(OFF_STATUS, 32'h2, 32'h3);
    scen(6'h03, 13'h0, {13'h1, 30'h0}, 2'h2, 13'h0, 13'h0, 7'h0);
    scen(6'h00, 13'h0, {13'h0, 13'h10, 17'h0}, 2'h3, 13'h10, 13'h0, 7'h55);
    scen(6'h00, 13'h0, {39'h0, 4'h4}, 2'h3, 13'h0, 13'h0, 7'h60);
    scen(6'h00, 13'h0, {39'h0, 4'h8}, 2'h3, 13'h0, 13'h0, 7'h70);
    scen(6'h01, 13'h0, {13'h0, 13'h10, 17'h0}, 2'h2, 13'h10, 13'h0, 7'h0);
    scen(6'h02, 13'h0, {39'h0, 4'h4}, 2'h2, 13'h0, 13'h0, 7'h0);
    scen(6'h00, 13'h0, {41'h0, 2'h1}, 2'h2, 13'h0, 13'h0, 7'h0);
    scen(6'h08, 13'h0, {41'h0, 2'h2}, 2'h1, 13'h0, 13'h0, 7'h0);
    scen(6'h02, 13'h0, {26'h0, 13'h1000, 4'h0}, 2'h3, 13'h0, 13'h1000, 7'h0);
    scen(6'h10, 13'h0, '0, 2'h2, 13'h0, 13'h0, 7'h0);
    scen(6'h29, 13'h0, '0, 2'h1, 13'h0, 13'h0, 7'h0);
    scen(6'h06, 13'h0, {13'h200, 30'h0}, 2'h0, 13'h0, 13'h0, 7'h0);
    // Both sides of the bus split, then one random slot
    for (int i = 0; i < 3; i++) begin
      s = (i < 2) ? 6 + i : $urandom_range(0, 12);
      scen(6'h0a, 13'h0, {13'h1 << s, 30'h0}, (s < 7) ? 2'h2 : 2'h1, 13'h0, 13'h0, 7'h0);
    end
    give_verdict();
  end
endmodule : tb
